//--- hw/powerline_ask_modem_core.v
// Digital core of a power-line ASK modem: carrier synthesis and shaping,
// line driver control, AGC, receive filtering, demodulation and shaping.
// Assumes host pins arrive asynchronously and converter signals are on i_clk.
//
// Operation
// - Burst on line while tx pin low
// - Line output released when not transmitting
// - Back-to-back bits keep carrier continuous
// - Receive pin low throughout detected burst
// - Sleep disables everything except clock and sample FIFO input
// - Clock output keeps running during sleep
// - Receive path stays active while transmitting
// - Save gain, force -6 dB, restore after
// - AGC range -6 dB to +30 dB
// - 8-bit samples, band-pass, demodulate, shape
// - Carrier stepped from lookup table by clock
// - Amplitude ramps smoothly, not switched
// - 6-bit DAC updated every clock
// - 600 or 1200 baud paced by host
// - All frequencies scale with master clock
`timescale 1ns/1ps
`include "ask_modem_map.vh"

module powerline_ask_modem_core
#(
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW = 4
)
(
    // Clock and reset
    input wire i_clk,
    input wire i_rstn,
    // Host pins
    input wire i_tx_data_n,
    output reg o_rx_data_n,
    input wire i_sleep_request,
    output wire o_clk_out,
    // Production test pins
    input wire i_production_scan_select,
    input wire i_factory_test_strap,
    // Line transmit path
    output reg [5:0] o_dac_code,
    output reg o_line_drive_en,
    // Line receive path
    output reg [3:0] o_gain_code,
    output reg o_adc_start,
    input wire i_adc_valid,
    output wire o_adc_ready,
    input wire [7:0] i_adc_data
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    reg [3:0] pin_meta_ff;
    reg [3:0] pin_sync_ff;
    wire tx_req;
    wire halt;
    reg [5:0] phase_ff;
    reg [4:0] env_ff;
    reg [4:0] nxt_env;
    wire [4:0] rom_mag;
    wire rom_neg;
    wire [9:0] prod;
    wire [4:0] scaled;
    reg [5:0] nxt_dac;
    reg [3:0] adc_div_ff;
    wire fifo_valid;
    wire [7:0] fifo_data;
    wire take;
    reg signed [8:0] x0_ff;
    reg signed [8:0] x1_ff;
    reg signed [8:0] x2_ff;
    reg sample_ff;
    wire signed [9:0] bp;
    wire [9:0] rect;
    reg [13:0] acc_ff;
    reg det_raw_ff;
    reg rx_active_ff;
    reg [3:0] shape_ff;
    reg [7:0] peak_ff;
    wire [7:0] mag_x;
    reg [7:0] win_ff;
    reg [3:0] gain_ff;
    reg [3:0] saved_gain_ff;
    reg tx_prev_ff;

    // ------------------------------------------------------------------------
    // Clock output and pin synchronisers
    // ------------------------------------------------------------------------
    // Clock buffer is never gated, so the host keeps its clock in sleep
    assign o_clk_out = i_clk;

    // Two-stage sync of tx_n, sleep, scan select and strap
    always @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            pin_meta_ff <= `PIN_RST;
            pin_sync_ff <= `PIN_RST;
        end
        else
        begin
            pin_meta_ff <= {i_factory_test_strap, i_production_scan_select,
                            i_sleep_request, i_tx_data_n};
            pin_sync_ff <= pin_meta_ff;
        end
    end

    // Test pins at non-functional levels also park the modem
    assign halt = pin_sync_ff[1] | pin_sync_ff[2] | ~pin_sync_ff[3];
    // Level-driven request; host paces bits at its chosen baud
    assign tx_req = ~pin_sync_ff[0] & ~halt;

    // ------------------------------------------------------------------------
    // Carrier phase and lookup
    // ------------------------------------------------------------------------
    // One phase step per clock: carrier is clock over 64
    always @(posedge i_clk)
    begin
        if (!i_rstn)
            phase_ff <= 6'h00;
        else
            phase_ff <= phase_ff + 1'b1;
    end

    carrier_rom u_rom
    (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_phase(phase_ff),
        .o_mag(rom_mag),
        .o_neg(rom_neg)
    );

    // ------------------------------------------------------------------------
    // Amplitude shaping
    // ------------------------------------------------------------------------
    // Envelope moves one step per carrier period, at the zero crossing,
    // so a burst edge takes 16 periods instead of a hard switch
    always @*
    begin
        nxt_env = env_ff;
        if (halt)
            nxt_env = 5'h00;
        else if (phase_ff == 6'h00)
        begin
            if (tx_req && env_ff != `ENV_MAX)
                nxt_env = env_ff + 1'b1;
            else if (!tx_req && env_ff != 5'h00)
                nxt_env = env_ff - 1'b1;
        end
    end

    // Held at full scale while tx stays low: NRZ, no gap between bits
    always @(posedge i_clk)
    begin
        if (!i_rstn)
            env_ff <= 5'h00;
        else
            env_ff <= nxt_env;
    end

    // Scale table magnitude by envelope over 16
    assign prod = rom_mag * env_ff;
    assign scaled = prod[8:4];

    // Offset binary around mid code
    always @*
    begin
        if (rom_neg)
            nxt_dac = `DAC_MID - {1'b0, scaled};
        else
            nxt_dac = `DAC_MID + {1'b0, scaled};
    end

    // ------------------------------------------------------------------------
    // DAC and line driver
    // ------------------------------------------------------------------------
    // DAC refreshed every clock, far above carrier, to push aliases out
    // Driver stays enabled until the ramp-down has finished
    always @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            o_dac_code <= `DAC_MID;
            o_line_drive_en <= 1'b0;
        end
        else
        begin
            o_dac_code <= nxt_dac;
            o_line_drive_en <= ~halt & (tx_req | (env_ff != 5'h00));
        end
    end

    // ------------------------------------------------------------------------
    // Converter pacing and sample buffer
    // ------------------------------------------------------------------------
    // Conversion rate tied to the clock so the filter tracks the carrier
    always @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            adc_div_ff <= 4'h0;
            o_adc_start <= 1'b0;
        end
        else
        begin
            adc_div_ff <= adc_div_ff + 1'b1;
            o_adc_start <= ~halt & (adc_div_ff == 4'hF);
        end
    end

    // Drain stalls in sleep, so samples back up and refuse further input
    sample_fifo
    #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    )
    u_fifo
    (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_wr_valid(i_adc_valid),
        .o_wr_ready(o_adc_ready),
        .i_wr_data(i_adc_data),
        .o_rd_valid(fifo_valid),
        .i_rd_ready(~halt),
        .o_rd_data(fifo_data)
    );

    assign take = fifo_valid & ~halt;

    // ------------------------------------------------------------------------
    // Band-pass and rectifier
    // ------------------------------------------------------------------------
    // Four samples per carrier period; x[n]-x[n-2] nulls DC and fs/2
    // Receive is not gated by tx, so our own burst is heard too
    always @(posedge i_clk)
    begin
        if (!i_rstn || halt)
        begin
            x0_ff <= 9'sh000;
            x1_ff <= 9'sh000;
            x2_ff <= 9'sh000;
            sample_ff <= 1'b0;
        end
        else
        begin
            sample_ff <= take;
            if (take)
            begin
                x0_ff <= $signed({1'b0, fifo_data}) - $signed({1'b0, `ADC_MID});
                x1_ff <= x0_ff;
                x2_ff <= x1_ff;
            end
        end
    end

    assign bp = {x0_ff[8], x0_ff} - {x2_ff[8], x2_ff};
    assign rect = bp[9] ? (~bp + 1'b1) : bp;
    assign mag_x = x0_ff[8] ? ((~x0_ff[7:0]) + 1'b1) : x0_ff[7:0];

    // ------------------------------------------------------------------------
    // Demodulator
    // ------------------------------------------------------------------------
    // Leaky integrator of the rectified output, gain 16 in steady state;
    // hysteresis keeps noise near threshold from chattering
    always @(posedge i_clk)
    begin
        if (!i_rstn || halt)
        begin
            acc_ff <= 14'h0000;
            det_raw_ff <= 1'b0;
        end
        else if (sample_ff)
        begin
            acc_ff <= acc_ff + {4'h0, rect} - {4'h0, acc_ff[13:4]};
            if (acc_ff > `DET_ON)
                det_raw_ff <= 1'b1;
            else if (acc_ff < `DET_OFF)
                det_raw_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Pulse shaping and receive pin
    // ------------------------------------------------------------------------
    // Output flips only after SHAPE_CNT agreeing samples, so short spikes
    // never reach the host; the cost is a fixed latency on both edges
    always @(posedge i_clk)
    begin
        if (!i_rstn || halt)
        begin
            shape_ff <= 4'h0;
            rx_active_ff <= 1'b0;
        end
        else if (sample_ff)
        begin
            if (det_raw_ff == rx_active_ff)
                shape_ff <= 4'h0;
            else if (shape_ff == `SHAPE_CNT - 1'b1)
            begin
                shape_ff <= 4'h0;
                rx_active_ff <= det_raw_ff;
            end
            else
                shape_ff <= shape_ff + 1'b1;
        end
    end

    // Low for the whole burst, high when idle or asleep
    always @(posedge i_clk)
    begin
        if (!i_rstn)
            o_rx_data_n <= 1'b1;
        else
            o_rx_data_n <= halt | ~rx_active_ff;
    end

    // ------------------------------------------------------------------------
    // Automatic gain control
    // ------------------------------------------------------------------------
    // Peak of |x| over a 256-sample window; step 3 dB per window, frozen
    // while transmitting so the stored gain is the pre-burst one
    always @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            peak_ff <= 8'h00;
            win_ff <= 8'h00;
            gain_ff <= `GAIN_RESET;
        end
        else if (halt || tx_req)
        begin
            peak_ff <= 8'h00;
            win_ff <= 8'h00;
        end
        else if (sample_ff)
        begin
            win_ff <= win_ff + 1'b1;
            if (win_ff == 8'hFF)
            begin
                peak_ff <= 8'h00;
                if (peak_ff > `AGC_HI && gain_ff != `GAIN_MIN)
                    gain_ff <= gain_ff - 1'b1;
                else if (peak_ff < `AGC_LO && gain_ff != `GAIN_MAX)
                    gain_ff <= gain_ff + 1'b1;
            end
            else if (mag_x > peak_ff)
                peak_ff <= mag_x;
        end
    end

    // ------------------------------------------------------------------------
    // Gain override during transmit
    // ------------------------------------------------------------------------
    // Snapshot on tx start, -6 dB while tx low, snapshot back afterwards
    always @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            tx_prev_ff <= 1'b0;
            saved_gain_ff <= `GAIN_RESET;
            o_gain_code <= `GAIN_RESET;
        end
        else
        begin
            tx_prev_ff <= tx_req;
            if (tx_req && !tx_prev_ff)
                saved_gain_ff <= gain_ff;
            if (tx_req)
                o_gain_code <= `GAIN_TX;
            else if (tx_prev_ff)
                o_gain_code <= saved_gain_ff;
            else
                o_gain_code <= gain_ff;
        end
    end

endmodule

//--- pkg/ask_modem_map.vh
// Constants for the power-line ASK modem core: timing counts, reset values,
// gain codes and detector thresholds.
// Assumes inclusion by bare name from the hw/ design files.
`ifndef ASK_MODEM_MAP_VH
`define ASK_MODEM_MAP_VH

// --------------------
// Clock and carrier
// --------------------
`define CLK_HZ 40000000
`define PHASE_W 6
`define CARRIER_DIV 64
`define ADC_DIV 16
`define ADC_DIV_W 4

// --------------------
// Transmit shaping
// --------------------
`define ENV_W 5
`define ENV_MAX 5'h10
`define DAC_W 6
`define DAC_MID 6'h20

// --------------------
// Receive gain: code 0 is -6 dB, each step +3 dB, code 12 is +30 dB
// --------------------
`define GAIN_W 4
`define GAIN_MIN 4'h0
`define GAIN_MAX 4'hC
`define GAIN_TX 4'h0
`define GAIN_RESET 4'h6
`define AGC_WIN_W 8
`define AGC_HI 8'h60
`define AGC_LO 8'h20

// --------------------
// Detector and pulse shaping
// --------------------
`define ACC_W 14
`define DET_ON 14'h0400
`define DET_OFF 14'h0200
`define SHAPE_W 4
`define SHAPE_CNT 4'h8
`define ADC_MID 8'h80

// --------------------
// Pin synchroniser reset: strap 1, scan 0, sleep 0, tx_n 1
// --------------------
`define PIN_RST 4'h9

`endif

//--- hw/carrier_rom.v
// Quarter-wave carrier lookup table with registered magnitude and sign.
// Assumes one phase step per clock; full period is 2^PHASE_W entries.
`timescale 1ns/1ps
`include "ask_modem_map.vh"

module carrier_rom
(
    // Clock and reset
    input wire i_clk,
    input wire i_rstn,
    // Phase in
    input wire [5:0] i_phase,
    // Sample out
    output reg [4:0] o_mag,
    output reg o_neg
);

    reg [3:0] idx;
    reg [4:0] mag;

    // ------------------------------------------------------------------------
    // Quadrant folding and table
    // ------------------------------------------------------------------------
    // Mirror the index in quadrants 1 and 3, sign from the top bit
    always @*
    begin
        idx = i_phase[4] ? ~i_phase[3:0] : i_phase[3:0];
        case (idx)
            4'h0: mag = 5'h02;
            4'h1: mag = 5'h05;
            4'h2: mag = 5'h08;
            4'h3: mag = 5'h0A;
            4'h4: mag = 5'h0D;
            4'h5: mag = 5'h10;
            4'h6: mag = 5'h12;
            4'h7: mag = 5'h15;
            4'h8: mag = 5'h17;
            4'h9: mag = 5'h19;
            4'hA: mag = 5'h1B;
            4'hB: mag = 5'h1C;
            4'hC: mag = 5'h1D;
            4'hD: mag = 5'h1E;
            4'hE: mag = 5'h1F;
            default: mag = 5'h1F;
        endcase
    end

    // Registered read keeps the DAC path glitch free
    always @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            o_mag <= 5'h00;
            o_neg <= 1'b0;
        end
        else
        begin
            o_mag <= mag;
            o_neg <= i_phase[5];
        end
    end

endmodule

//--- hw/sample_fifo.v
// Sample FIFO with registered read data and valid/ready on both sides.
// Assumes one clock; DEPTH is a power of two equal to 2^AW.
`timescale 1ns/1ps

module sample_fifo
#(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
)
(
    // Clock and reset
    input wire i_clk,
    input wire i_rstn,
    // Fill side
    input wire i_wr_valid,
    output wire o_wr_ready,
    input wire [WIDTH-1:0] i_wr_data,
    // Drain side
    output wire o_rd_valid,
    input wire i_rd_ready,
    output reg [WIDTH-1:0] o_rd_data
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_ff;
    reg [AW-1:0] rd_ptr_ff;
    reg [AW:0] count_ff;
    reg out_valid_ff;
    wire push;
    wire pop;

    // ------------------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------------------
    // Output stage refills when empty or being taken
    assign o_wr_ready = (count_ff != DEPTH[AW:0]);
    assign o_rd_valid = out_valid_ff;
    assign push = i_wr_valid & o_wr_ready;
    assign pop = (count_ff != {(AW+1){1'b0}}) & (~out_valid_ff | i_rd_ready);

    // Storage has no reset, pointers do
    always @(posedge i_clk)
    begin
        if (push)
            mem[wr_ptr_ff] <= i_wr_data;
    end

    // Pointers, count and registered output word
    always @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            count_ff <= {(AW+1){1'b0}};
            out_valid_ff <= 1'b0;
            o_rd_data <= {WIDTH{1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            if (pop)
            begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
                o_rd_data <= mem[rd_ptr_ff];
                out_valid_ff <= 1'b1;
            end
            else if (i_rd_ready)
                out_valid_ff <= 1'b0;
            if (push & ~pop)
                count_ff <= count_ff + 1'b1;
            else if (pop & ~push)
                count_ff <= count_ff - 1'b1;
        end
    end

endmodule

//--- sim/ask_modem_checker.sv
// Port checker for the power-line ASK modem core.
// Assumes a bind from the bench top; one clock, synchronous active-low reset.
`timescale 1ns/1ps

module ask_modem_checker
#(
    parameter FIFO_DEPTH = 16
)
(
    // Clock and reset
    input wire i_clk,
    input wire i_rstn,
    // Host pins
    input wire i_tx_data_n,
    input wire o_rx_data_n,
    input wire i_sleep_request,
    input wire i_production_scan_select,
    input wire i_factory_test_strap,
    // Line side
    input wire [5:0] o_dac_code,
    input wire o_line_drive_en,
    input wire [3:0] o_gain_code,
    input wire o_adc_start,
    input wire o_adc_ready
);
    // --------------------
    // Helper logic
    // --------------------
    wire run = !i_sleep_request && !i_production_scan_select && i_factory_test_strap;
    reg [11:0] idle_ff;

    // Cycles since tx was last requested; saturates so it never wraps
    always @(posedge i_clk)
    begin
        if (!i_rstn || (!i_tx_data_n && run))
            idle_ff <= 12'h000;
        else if (idle_ff != 12'hFFF)
            idle_ff <= idle_ff + 12'h001;
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    // --------------------
    // Assertions
    // --------------------
    drive_rise_a: assert property ((!i_tx_data_n && run) [*4] |=> o_line_drive_en)
        else $error("line driver off while tx requested");
    tx_gain_a: assert property ((!i_tx_data_n && run) [*4] |=> o_gain_code == 4'h0)
        else $error("gain not forced low during tx");
    line_idle_a: assert property (idle_ff > 12'h4B0 |-> !o_line_drive_en)
        else $error("line driven long after tx ended");
    gain_range_a: assert property (o_gain_code <= 4'hC)
        else $error("gain code out of range");
    soft_start_a: assert property ($rose(o_line_drive_en) |-> (o_dac_code >= 6'h1E && o_dac_code <= 6'h22) [*8])
        else $error("carrier switched on abruptly");
    dac_step_a: assert property (o_line_drive_en && $past(o_line_drive_en)
        |-> ((o_dac_code - $past(o_dac_code) + 6'h06) & 6'h3F) <= 6'h0C)
        else $error("dac step too large");
    sleep_rx_a: assert property (i_sleep_request [*4] |-> o_rx_data_n)
        else $error("rx active during sleep");
    sleep_adc_a: assert property (i_sleep_request [*4] |-> !o_adc_start)
        else $error("conversion started during sleep");
    adc_gap_a: assert property (o_adc_start |=> !o_adc_start [*8])
        else $error("conversion starts too close");

    cover property ($rose(o_line_drive_en));
    cover property ($fell(o_rx_data_n));
    cover property (!o_adc_ready);
endmodule

//--- sim/line_front_model.sv
// Line front-end model: an ADC answering conversion starts with samples.
// Assumes the core's clock; loops the core's own DAC back while it drives.
`timescale 1ns/1ps

module line_front_model
(
    // Clock and reset
    input wire i_clk,
    input wire i_rstn,
    // Core side
    input wire i_adc_start,
    input wire i_adc_ready,
    input wire [5:0] i_dac_code,
    input wire i_line_drive_en,
    output reg o_adc_valid,
    output reg [7:0] o_adc_data,
    // Scenario controls
    input wire i_burst,
    input wire i_flood,
    input wire i_slow
);
    reg pend_ff;
    reg [1:0] dly_ff;
    reg [1:0] ph_ff;
    // Foreign burst is a strong four-sample carrier
    wire [7:0] pat = ph_ff[0] ? (ph_ff[1] ? 8'h10 : 8'hF0) : 8'h80;
    wire [7:0] smp = i_burst ? pat : (i_line_drive_en ? {i_dac_code, 2'b00} : 8'h80);

    // Hold each sample until taken; scramble the bus after so stale data never matches
    always @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            o_adc_valid <= 1'b0;
            o_adc_data <= 8'h00;
            pend_ff <= 1'b0;
            dly_ff <= 2'h0;
            ph_ff <= 2'h0;
        end
        else
        begin
            if (o_adc_valid && i_adc_ready)
            begin
                o_adc_valid <= 1'b0;
                o_adc_data <= ~o_adc_data;
            end
            else if (!o_adc_valid && pend_ff)
            begin
                if (dly_ff == 2'h0)
                begin
                    o_adc_valid <= 1'b1;
                    o_adc_data <= smp;
                    ph_ff <= ph_ff + 2'h1;
                    pend_ff <= 1'b0;
                end
                else
                    dly_ff <= dly_ff - 2'h1;
            end
            if (i_adc_start || (i_flood && !pend_ff && !o_adc_valid))
            begin
                pend_ff <= 1'b1;
                dly_ff <= i_slow ? 2'h3 : 2'h0;
            end
        end
    end
endmodule

//--- sim/tb_powerline_ask_modem_core.sv
// Self-checking bench for the power-line ASK modem core.
// Assumes the line front-end model and the port checker alongside.
`timescale 1ns/1ps

module tb_powerline_ask_modem_core;
    localparam int FIFO_DEPTH = 16;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic tx_n = 1'b1;
    logic sleep = 1'b0;
    logic scan = 1'b0;
    logic strap = 1'b1;
    logic burst = 1'b0;
    logic flood = 1'b0;
    logic slow = 1'b0;
    wire rx_n;
    wire clk_out;
    wire [5:0] dac;
    wire drive;
    wire [3:0] gain;
    wire start;
    wire valid;
    wire ready;
    wire [7:0] data;
    int n_fail = 0;
    int total_checks = 0;
    int acc_cnt = 0;
    int tog = 0;

    // --------------------
    // Design and partner
    // --------------------
    powerline_ask_modem_core #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(4)) u_powerline_ask_modem_core (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_tx_data_n(tx_n), .o_rx_data_n(rx_n),
        .i_sleep_request(sleep), .o_clk_out(clk_out), .i_production_scan_select(scan),
        .i_factory_test_strap(strap), .o_dac_code(dac), .o_line_drive_en(drive),
        .o_gain_code(gain), .o_adc_start(start), .i_adc_valid(valid), .o_adc_ready(ready),
        .i_adc_data(data));
    line_front_model u_line_front_model (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_adc_start(start), .i_adc_ready(ready),
        .i_dac_code(dac), .i_line_drive_en(drive), .o_adc_valid(valid), .o_adc_data(data),
        .i_burst(burst), .i_flood(flood), .i_slow(slow));

    // Clock
    initial
    begin
        forever #12.5 i_clk = ~i_clk;
    end

    // Samples taken by the FIFO, and clock-out edges
    always @(posedge i_clk)
    begin
        if (valid && ready)
            acc_cnt++;
    end
    always @(clk_out)
    begin
        tog++;
    end

    // --------------------
    // Helpers
    // --------------------
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task final_report;
        if (n_fail == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Inputs always move 2 ns after a rising edge
    task step(input int n);
        repeat (n) @(posedge i_clk);
        #2;
    endtask

    // --------------------
    // Scenarios
    // --------------------
    task test_reset;
        check("rx idle", rx_n, 1'b1);
        check("line idle", drive, 1'b0);
        check("gain reset", gain, 4'h6);
        check("dac rest", dac, 6'h20);
        check("fifo ready", ready, 1'b1);
    endtask

    // Two back-to-back low bits at 1200 baud, then release
    task test_tx;
        int i;
        int gaps;
        int lo;
        int mism;
        int pk;
        logic [5:0] w [0:127];
        tx_n = 1'b0;
        step(2);
        check("drive early", drive, 1'b0);
        step(1);
        check("drive on", drive, 1'b1);
        check("gain tx", gain, 4'h0);
        gaps = 0;
        lo = 0;
        mism = 0;
        pk = 0;
        for (i = 0; i < 66666; i++)
        begin
            step(1);
            gaps += (drive !== 1'b1);
            lo += (rx_n === 1'b0);
            if (i >= 2000 && i < 2128)
                w[i - 2000] = dac;
        end
        for (i = 0; i < 64; i++)
        begin
            mism += (w[i] !== w[i + 64]);
            if (w[i] > 6'h20 && w[i] - 6'h20 > pk)
                pk = w[i] - 6'h20;
        end
        check("carrier gaps", gaps, 0);
        check("own detect", lo > 0, 1'b1);
        check("carrier period", mism, 0);
        check("carrier swing", pk >= 16, 1'b1);
        tx_n = 1'b1;
        step(2);
        check("gain held", gain, 4'h0);
        step(1);
        check("gain restored", gain, 4'h6);
        for (i = 0; i < 1200 && drive !== 1'b0; i++)
            step(1);
        check("line released", drive, 1'b0);
        check("dac settled", dac, 6'h20);
        for (i = 0; i < 4096 && rx_n !== 1'b1; i++)
            step(1);
        check("rx after tx", rx_n, 1'b1);
    endtask

    // Foreign burst with a slow converter
    task test_rx;
        int i;
        int hi;
        slow = 1'b1;
        burst = 1'b1;
        for (i = 0; i < 4096 && rx_n !== 1'b0; i++)
            step(1);
        check("rx detect", rx_n, 1'b0);
        hi = 0;
        for (i = 0; i < 1000; i++)
        begin
            step(1);
            hi += (rx_n !== 1'b0);
        end
        check("rx steady", hi, 0);
        burst = 1'b0;
        for (i = 0; i < 4096 && rx_n !== 1'b1; i++)
            step(1);
        check("rx end", rx_n, 1'b1);
        check("no tx burst", drive, 1'b0);
        slow = 1'b0;
    endtask

    // Sleep, scan and strap each halt the core; sleep also fills the FIFO
    task test_halt;
        int k;
        int i;
        int st;
        int dr;
        int hi;
        for (k = 0; k < 3; k++)
        begin
            sleep = (k == 0);
            scan = (k == 1);
            strap = (k != 2);
            tx_n = 1'b0;
            acc_cnt = 0;
            step(4);
            tog = 0;
            flood = (k == 0);
            st = 0;
            dr = 0;
            hi = 0;
            for (i = 0; i < 300; i++)
            begin
                step(1);
                st += (start === 1'b1);
                dr += (drive === 1'b1);
                hi += (rx_n === 1'b1);
            end
            check("halt starts", st, 0);
            check("halt drive", dr, 0);
            check("halt rx", hi, 300);
            check("clock out", tog, 600);
            if (k == 0)
            begin
                check("fifo fill", acc_cnt, FIFO_DEPTH + 1);
                check("fifo full", ready, 1'b0);
            end
            sleep = 1'b0;
            scan = 1'b0;
            strap = 1'b1;
            tx_n = 1'b1;
            flood = 1'b0;
            for (i = 0; i < 100 && ready !== 1'b1; i++)
                step(1);
            check("fifo drains", ready, 1'b1);
        end
    endtask

    // --------------------
    // Main sequence and watchdog
    // --------------------
    initial
    begin
        repeat (12) @(posedge i_clk);
        #2;
        i_rstn = 1'b1;
        step(1);
        test_reset();
        test_tx();
        test_rx();
        test_halt();
        final_report();
    end

    initial
    begin
        #2375000;
        n_fail++;
        final_report();
    end
endmodule

bind powerline_ask_modem_core ask_modem_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_ask_modem_checker (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_tx_data_n(i_tx_data_n), .o_rx_data_n(o_rx_data_n),
    .i_sleep_request(i_sleep_request), .i_production_scan_select(i_production_scan_select),
    .i_factory_test_strap(i_factory_test_strap), .o_dac_code(o_dac_code),
    .o_line_drive_en(o_line_drive_en), .o_gain_code(o_gain_code), .o_adc_start(o_adc_start),
    .o_adc_ready(o_adc_ready));
